// file: logic/gcim_pkg.sv
`default_nettype none
package gcim_pkg;
  // monitor channel command codes, bit 0 selects read
  localparam logic [7:0] CMD_KEYINT_WR = 8'he8;
  localparam logic [7:0] CMD_KEYINT_RD = 8'he9;
  localparam logic [7:0] CMD_RT_RD     = 8'h4d;
  localparam logic [7:0] CMD_RT_RD_CLR = 8'h4f;
  localparam logic [7:0] CMD_MASK_WR   = 8'h6c;
  localparam logic [7:0] CMD_MASK_RD   = 8'h6d;
  localparam logic [7:0] CMD_SCALE_WR  = 8'h50;
  localparam logic [7:0] CMD_SCALE_RD  = 8'h51;
  localparam logic [7:0] CMD_TXGAIN_WR = 8'h80;
  localparam logic [7:0] CMD_TXGAIN_RD = 8'h81;
  localparam int         RW_BIT        = 0;
  localparam int         CLR_BIT       = 1;
  // field positions of the impedance scaling and gains byte, and interval MSB
  localparam int         ATTEN_DIS_BIT = 7;
  localparam int         TX_GAIN_BIT   = 6;
  localparam int         RX_LOSS_BIT   = 5;
  localparam int         KEYINT_MSB    = 3;
  // values after reset, loopback code, scaling offset and coefficient byte limit
  localparam logic [7:0]  KEYINT_RST      = 8'h00;
  localparam logic [7:0]  MASK_RST        = 8'hff;
  localparam logic [7:0]  SCALE_RST       = 8'h00;
  localparam logic [15:0] TXGAIN_RST      = 16'ha9f0;
  localparam logic [4:0]  LOOPBACK_CODE   = 5'h10;
  localparam logic [5:0]  SCALE_OFFSET    = 6'h10;
  localparam logic [3:0]  MAX_COEFF_BYTES = 4'he;
  // timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          ONE_MS_NS     = 1000000;
  localparam int          MS_CYCLES_DEF = ONE_MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    ST_ADDR  = 3'b000,
    ST_CMD   = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011
  } gcim_state_e;
endpackage : gcim_pkg
`default_nettype wire

// file: logic/gcim_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gcim_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds the second stage only
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : gcim_sync
`default_nettype wire

// file: logic/gcim_gk_filter.sv
`timescale 1ns/100ps
`default_nettype none
module gcim_gk_filter
  import gcim_pkg::*;
#(
  parameter int CH        = 4,
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic [3:0]    interval_ms,
  input  wire logic [CH-1:0] raw,
  output var  logic [CH-1:0] filt_r
);
  if (MS_CYCLES < 1 || CH < 1)
  begin : g_bad_param
    $error("gcim_gk_filter: bad parameters");
  end

  logic [31:0] ms_cnt_r;
  logic [3:0]  per_cnt_r;
  logic        ms_tick;
  logic        sample;

  assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
  // interval zero means no filtering: follow the input every cycle
  assign sample  = (interval_ms == 4'h0) || (ms_tick && (per_cnt_r + 4'h1 >= interval_ms));

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ms_cnt_r <= '0;
    else if (ms_tick)
      ms_cnt_r <= '0;
    else
      ms_cnt_r <= ms_cnt_r + 32'h1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      per_cnt_r <= '0;
    else if (sample)
      per_cnt_r <= '0;
    else if (ms_tick)
      per_cnt_r <= per_cnt_r + 4'h1;
  end

  genvar k;
  generate
    for (k = 0; k < CH; k++)
    begin : g_ch
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
          filt_r[k] <= 1'b0;
        else if (sample)
          filt_r[k] <= raw[k];
      end
    end
  endgenerate
endmodule : gcim_gk_filter
`default_nettype wire

// file: logic/gcim_monitor_cmd_regs.sv
// Contract
// (RULE1) command bit 0 low means write following data, high means read reply
// (RULE2) E8h writes, E9h reads the ground-key sampling interval
// (RULE3) interval held in bits 3..0, value 0 to 15 milliseconds
// (RULE4) interval samples second signalling bit before it reaches upstream C/I
// (RULE5) reserved bits written zero by controller; reads may return anything
// (RULE6) reset clears ground-key interval low nibble
// (RULE7) 4Dh and 4Fh read real-time data; command bit 1 is clear flag
// (RULE8) clear flag set drops pending interrupt after the reply; otherwise kept
// (RULE9) real-time byte: two bits per channel 1..4, debounced bit even
// (RULE10) same real-time bits go to upstream C/I field continuously
// (RULE11) 6Ch writes, 6Dh reads interrupt mask, one bit per data bit
// (RULE12) masked bit changes never pull interrupt low; unmasked changes may
// (RULE13) reset sets interrupt mask to all ones
// (RULE14) coefficient write is command plus 1 to 14 data bytes
// (RULE15) coefficient read returns up to 14 bytes upstream
// (RULE16) address, then command, then data; reply has no command byte
// (RULE17) 50h writes, 51h reads attenuator, gain, loss and 5-bit scaling code
// (RULE18) attenuator off when set; gain and loss 6.02 dB when set
// (RULE19) scaling gain is input gain times code minus 16, over 16
// (RULE20) scaling code 10000b selects full digital loopback
// (RULE21) 80h writes, 81h reads two transmit gain bytes, nibbles 4,3 then 2,1
// (RULE22) sign bit 0 is plus, 1 is minus, in nested gain product
// (RULE23) reset loads transmit gain word with A9F0h
// (RULE24) controller waits for a full read reply before the next command
`timescale 1ns/100ps
`default_nettype none
module gcim_monitor_cmd_regs
  import gcim_pkg::*;
#(
  parameter int CH        = 4,
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          link_clk,
  input  wire logic          mon_rx_valid,
  input  wire logic [7:0]    mon_rx_byte,
  input  wire logic          mon_rx_last,
  output var  logic          mon_tx_valid,
  output var  logic [7:0]    mon_tx_byte,
  output var  logic [7:0]    ci_upstream_bits,
  input  wire logic          mux_mode,
  input  wire logic [CH-1:0] debounced_sig_bit,
  input  wire logic [CH-1:0] muxed_sig_bit_one,
  input  wire logic [CH-1:0] sig_input_two,
  output var  logic          int_n,
  output var  logic          input_atten_disable,
  output var  logic          tx_analog_gain_sel,
  output var  logic          rx_analog_loss_sel,
  output var  logic [4:0]    impedance_scale_code,
  output var  logic [5:0]    impedance_scale_step,
  output var  logic          full_loopback,
  output var  logic [15:0]   transmit_gain_filter,
  output var  logic [3:0]    txgain_sign_neg,
  output var  logic [11:0]   coeff_shift_field
);
  if (CH != 4)
  begin : g_bad_ch
    $error("gcim_monitor_cmd_regs: real-time byte holds exactly four channels");
  end

  // link domain: downstream byte capture
  logic [8:0]  rx_hold_r;
  logic        rx_tgl_r;
  logic        tx_seen_r;
  logic        tx_req_lk;
  logic        tx_req_tgl_r;

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_hold_r <= '0;
      rx_tgl_r  <= 1'b0;
    end
    else if (mon_rx_valid)
    begin
      rx_hold_r <= {mon_rx_last, mon_rx_byte};
      rx_tgl_r  <= ~rx_tgl_r;
    end
  end

  // link domain: upstream byte emit, one pulse per core request
  logic [7:0] tx_byte_r;

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_seen_r    <= 1'b0;
      mon_tx_valid <= 1'b0;
      mon_tx_byte  <= '0;
    end
    else
    begin
      mon_tx_valid <= (tx_req_lk != tx_seen_r);
      if (tx_req_lk != tx_seen_r)
      begin
        mon_tx_byte <= tx_byte_r;
        tx_seen_r   <= tx_req_lk;
      end
    end
  end

  gcim_sync #(.W(1)) u_txreq_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    (tx_req_tgl_r),
    .q    (tx_req_lk)
  );

  // core domain crossings
  logic        rx_tgl_s;
  logic        rx_seen_r;
  logic        tx_ack_s;
  logic        rx_new;
  logic        tx_busy;
  logic [12:0] pins_s;

  gcim_sync #(.W(1)) u_rx_sync (
    .clk  (clock),
    .rstn (rstn),
    .d    (rx_tgl_r),
    .q    (rx_tgl_s)
  );

  gcim_sync #(.W(1)) u_ack_sync (
    .clk  (clock),
    .rstn (rstn),
    .d    (tx_seen_r),
    .q    (tx_ack_s)
  );

  gcim_sync #(.W(13)) u_pin_sync (
    .clk  (clock),
    .rstn (rstn),
    .d    ({mux_mode, muxed_sig_bit_one, sig_input_two, debounced_sig_bit}),
    .q    (pins_s)
  );

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rx_seen_r <= 1'b0;
    else
      rx_seen_r <= rx_tgl_s;
  end

  // hold word is stable well before its toggle passes the synchroniser
  assign rx_new  = (rx_tgl_s != rx_seen_r);
  assign tx_busy = (tx_req_tgl_r != tx_ack_s);

  // real-time signalling data
  logic [7:0]    keyint_r;
  logic [7:0]    mask_r;
  logic [7:0]    scale_r;
  logic [15:0]   txgain_r;
  logic [CH-1:0] second_raw;
  logic [CH-1:0] second_sig_bit;
  logic [7:0]    rt_now;
  logic [7:0]    rt_prev_r;
  logic          pend_r;
  logic          sig_event;
  logic          clr_pulse;

  assign second_raw = pins_s[12] ? pins_s[11:8] : pins_s[7:4];

  gcim_gk_filter #(.CH(CH), .MS_CYCLES(MS_CYCLES)) u_key_filter (
    .clock       (clock),
    .rstn        (rstn),
    .interval_ms (keyint_r[KEYINT_MSB:0]),
    .raw         (second_raw),
    .filt_r      (second_sig_bit)
  ); // RULE4

  genvar k;
  generate
    for (k = 0; k < CH; k++)
    begin : g_rt
      assign rt_now[2*k]   = pins_s[k]; // RULE9
      assign rt_now[2*k+1] = second_sig_bit[k]; // RULE9
    end
  endgenerate

  gcim_sync #(.W(8)) u_ci_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    (rt_prev_r),
    .q    (ci_upstream_bits)
  ); // RULE10

  assign sig_event = |((rt_now ^ rt_prev_r) & ~mask_r); // RULE12

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rt_prev_r <= '0;
    else
      rt_prev_r <= rt_now;
  end

  // a change arriving with the clear keeps the interrupt pending
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pend_r <= 1'b0;
    else if (sig_event)
      pend_r <= 1'b1; // RULE12
    else if (clr_pulse)
      pend_r <= 1'b0; // RULE8
  end

  assign int_n = ~pend_r;

  // command sequencer
  gcim_state_e state_r;
  logic [7:0]  cmd_r;
  logic [3:0]  dcnt_r;
  logic [1:0]  rd_len_r;
  logic [1:0]  rd_idx_r;
  logic [7:0]  rd_byte;
  logic [1:0]  rd_len_nxt;
  logic        wr_en;
  logic [7:0]  wdat;

  assign wdat  = rx_hold_r[7:0];
  assign wr_en = rx_new && (state_r == ST_WDATA) && (dcnt_r < MAX_COEFF_BYTES); // RULE14

  always_comb
  begin
    unique case (wdat)
      CMD_KEYINT_RD, CMD_RT_RD, CMD_RT_RD_CLR, CMD_MASK_RD, CMD_SCALE_RD: rd_len_nxt = 2'd1;
      CMD_TXGAIN_RD: rd_len_nxt = 2'd2; // RULE15
      default: rd_len_nxt = 2'd0;
    endcase
  end

  // reserved upper bits of the interval read back as zero
  always_comb
  begin
    unique case (cmd_r)
      CMD_KEYINT_RD: rd_byte = {4'h0, keyint_r[KEYINT_MSB:0]}; // RULE5
      CMD_RT_RD, CMD_RT_RD_CLR: rd_byte = rt_prev_r; // RULE7
      CMD_MASK_RD: rd_byte = mask_r; // RULE11
      CMD_SCALE_RD: rd_byte = scale_r; // RULE17
      CMD_TXGAIN_RD: rd_byte = (rd_idx_r == 2'd0) ? txgain_r[15:8] : txgain_r[7:0]; // RULE21
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r  <= ST_ADDR;
      cmd_r    <= '0;
      dcnt_r   <= '0;
      rd_len_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_ADDR:
          if (rx_new && !rx_hold_r[8])
            state_r <= ST_CMD; // RULE16
        ST_CMD:
          if (rx_new)
          begin
            cmd_r    <= wdat;
            dcnt_r   <= '0;
            rd_len_r <= rd_len_nxt;
            if (wdat[RW_BIT])
              state_r <= (rd_len_nxt != 2'd0) ? ST_RDATA : ST_ADDR; // RULE1
            else
              state_r <= rx_hold_r[8] ? ST_ADDR : ST_WDATA; // RULE1
          end
        ST_WDATA:
          if (rx_new)
          begin
            if (dcnt_r < MAX_COEFF_BYTES)
              dcnt_r <= dcnt_r + 4'h1;
            if (rx_hold_r[8])
              state_r <= ST_ADDR;
          end
        // downstream bytes during a reply are dropped
        ST_RDATA:
          if (!tx_busy && rd_idx_r == rd_len_r)
            state_r <= ST_ADDR; // RULE24
        default:
          state_r <= ST_ADDR;
      endcase
    end
  end

  // upstream reply: one byte per handshake, no command byte
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_idx_r     <= '0;
      tx_req_tgl_r <= 1'b0;
      tx_byte_r    <= '0;
    end
    else if (state_r != ST_RDATA)
      rd_idx_r <= '0;
    else if (!tx_busy && rd_idx_r != rd_len_r)
    begin
      tx_byte_r    <= rd_byte; // RULE16
      tx_req_tgl_r <= ~tx_req_tgl_r;
      rd_idx_r     <= rd_idx_r + 2'd1;
    end
  end

  assign clr_pulse = (state_r == ST_RDATA) && !tx_busy && (rd_idx_r == rd_len_r)
                     && (cmd_r == CMD_RT_RD_CLR) && cmd_r[CLR_BIT]; // RULE8

  // registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      keyint_r <= KEYINT_RST; // RULE6
    else if (wr_en && cmd_r == CMD_KEYINT_WR && dcnt_r == 4'h0)
      keyint_r <= {4'h0, wdat[KEYINT_MSB:0]}; // RULE2 RULE3
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mask_r <= MASK_RST; // RULE13
    else if (wr_en && cmd_r == CMD_MASK_WR && dcnt_r == 4'h0)
      mask_r <= wdat; // RULE11
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      scale_r <= SCALE_RST;
    else if (wr_en && cmd_r == CMD_SCALE_WR && dcnt_r == 4'h0)
      scale_r <= wdat; // RULE17
  end

  // byte 1 carries nibbles 4 and 3, byte 2 nibbles 2 and 1
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      txgain_r <= TXGAIN_RST; // RULE23
    else if (wr_en && cmd_r == CMD_TXGAIN_WR && dcnt_r == 4'h0)
      txgain_r[15:8] <= wdat; // RULE21
    else if (wr_en && cmd_r == CMD_TXGAIN_WR && dcnt_r == 4'h1)
      txgain_r[7:0] <= wdat; // RULE21
  end

  // decoded outputs for the analog front end and transmit filter
  assign input_atten_disable  = scale_r[ATTEN_DIS_BIT]; // RULE18
  assign tx_analog_gain_sel   = scale_r[TX_GAIN_BIT]; // RULE18
  assign rx_analog_loss_sel   = scale_r[RX_LOSS_BIT]; // RULE18
  assign impedance_scale_code = scale_r[4:0];
  // step in sixteenths of input gain; datapath multiplies by the attenuator gain
  assign impedance_scale_step = {1'b0, scale_r[4:0]} - SCALE_OFFSET; // RULE19
  assign full_loopback        = (scale_r[4:0] == LOOPBACK_CODE); // RULE20
  assign transmit_gain_filter = txgain_r;

  generate
    for (k = 0; k < 4; k++)
    begin : g_txgain
      // nibble k holds term k+1: sign high means minus one
      assign txgain_sign_neg[k]        = txgain_r[4*k+3]; // RULE22
      assign coeff_shift_field[3*k+:3] = txgain_r[4*k+:3]; // RULE22
    end
  endgenerate

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_read_dir;
    rx_new && state_r == ST_CMD && wdat[RW_BIT] && rd_len_nxt != 2'd0 |=> state_r == ST_RDATA;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read command not answered"); // RULE1

  property p_keyint_wr;
    wr_en && cmd_r == CMD_KEYINT_WR && dcnt_r == 4'h0 |=> keyint_r == {4'h0, $past(wdat[3:0])};
  endproperty
  a_keyint_wr: assert property (p_keyint_wr) else $error("interval write lost"); // RULE2

  property p_masked;
    !pend_r && ((rt_now ^ rt_prev_r) & ~mask_r) == 8'h00 |=> !pend_r;
  endproperty
  a_masked: assert property (p_masked) else $error("masked change raised interrupt"); // RULE12

  property p_clear;
    clr_pulse && !sig_event |=> int_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear read left interrupt"); // RULE8

  property p_keep;
    pend_r && state_r == ST_RDATA && cmd_r == CMD_RT_RD |=> pend_r;
  endproperty
  a_keep: assert property (p_keep) else $error("plain read cleared interrupt"); // RULE8

  property p_rt_map;
    ##1 rt_prev_r[0] == $past(pins_s[0]) && rt_prev_r[6] == $past(pins_s[3]);
  endproperty
  a_rt_map: assert property (p_rt_map) else $error("real-time bit order wrong"); // RULE9

  property p_txgain_pair;
    wr_en && cmd_r == CMD_TXGAIN_WR && dcnt_r == 4'h1 |=> txgain_r[7:0] == $past(wdat)
      && $stable(txgain_r[15:8]);
  endproperty
  a_txgain_pair: assert property (p_txgain_pair) else $error("second gain byte misplaced"); // RULE21

  property p_reply_len;
    state_r == ST_RDATA && cmd_r == CMD_TXGAIN_RD |-> rd_idx_r <= 2'd2;
  endproperty
  a_reply_len: assert property (p_reply_len) else $error("reply too long"); // RULE15

  property p_loop;
    $changed(scale_r) && scale_r[4:0] == 5'h10 |-> full_loopback && impedance_scale_step == 6'h00;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback code not decoded"); // RULE20
endmodule : gcim_monitor_cmd_regs
`default_nettype wire

// file: verif/gcim_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module gcim_ctrl_model (
  input  wire logic       link_clk,
  output var  logic       mon_rx_valid,
  output var  logic [7:0] mon_rx_byte,
  output var  logic       mon_rx_last,
  input  wire logic       mon_tx_valid,
  input  wire logic [7:0] mon_tx_byte
);
  logic [7:0] reply_q [$];

  initial
  begin
    mon_rx_valid = 1'b0;
    mon_rx_byte  = 8'h00;
    mon_rx_last  = 1'b0;
  end

  // reply pulses stand one link cycle, so take them on that edge
  always @(posedge link_clk)
    if (mon_tx_valid === 1'b1)
      reply_q.push_back(mon_tx_byte);

  task automatic put_byte(input logic [7:0] b, input logic last);
    @(posedge link_clk);
    #1;
    mon_rx_valid = 1'b1;
    mon_rx_byte  = b;
    mon_rx_last  = last;
    @(posedge link_clk);
    #1;
    mon_rx_valid = 1'b0;
    mon_rx_last  = 1'b0;
    // a released data line must not keep the last byte
    mon_rx_byte  = ~b;
    repeat (3) @(posedge link_clk);
  endtask : put_byte

  // address first, then command, then data; last byte closes the message
  task automatic send_msg(input logic [7:0] m [$], input int nrep);
    int n;
    reply_q.delete();
    foreach (m[i])
      put_byte(m[i], i == m.size() - 1);
    n = 0;
    while (reply_q.size() < nrep && n < 40)
    begin
      @(posedge link_clk);
      n++;
    end
    repeat (30) @(posedge link_clk);
  endtask : send_msg
endmodule : gcim_ctrl_model
`default_nettype wire

// file: verif/gcim_monitor_cmd_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module gcim_monitor_cmd_regs_test;
  import gcim_pkg::*;
  logic        clock;
  logic        link_clk;
  logic        rstn;
  logic        mux_mode;
  logic [3:0]  deb;
  logic [3:0]  mux1;
  logic [3:0]  in2;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_last;
  logic        tx_valid;
  logic [7:0]  tx_byte;
  logic [7:0]  ci;
  logic        int_n;
  logic        atten;
  logic        again;
  logic        rloss;
  logic [4:0]  code;
  logic [5:0]  step;
  logic        loopb;
  logic [15:0] gxw;
  logic [3:0]  gxs;
  logic [11:0] gxm;
  int          mismatches;
  int          checks;

  gcim_monitor_cmd_regs #(.CH(4), .MS_CYCLES(10)) i_dut (
    .clock(clock), .rstn(rstn), .link_clk(link_clk), .mon_rx_valid(rx_valid),
    .mon_rx_byte(rx_byte), .mon_rx_last(rx_last), .mon_tx_valid(tx_valid),
    .mon_tx_byte(tx_byte), .ci_upstream_bits(ci), .mux_mode(mux_mode),
    .debounced_sig_bit(deb), .muxed_sig_bit_one(mux1), .sig_input_two(in2),
    .int_n(int_n), .input_atten_disable(atten), .tx_analog_gain_sel(again),
    .rx_analog_loss_sel(rloss), .impedance_scale_code(code),
    .impedance_scale_step(step), .full_loopback(loopb),
    .transmit_gain_filter(gxw), .txgain_sign_neg(gxs), .coeff_shift_field(gxm));

  gcim_ctrl_model i_ctrl (
    .link_clk(link_clk), .mon_rx_valid(rx_valid), .mon_rx_byte(rx_byte),
    .mon_rx_last(rx_last), .mon_tx_valid(tx_valid), .mon_tx_byte(tx_byte));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // phase offset staggers the link edges, but every fifth link edge still lands on a core edge
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] c, input logic [15:0] d, input int nd, input int nrep);
    logic [7:0] m [$];
    m = '{8'h01, c};
    if (nd > 0) m.push_back(d[15:8]);
    if (nd > 1) m.push_back(d[7:0]);
    if (nd > 2) m.push_back(8'h00);
    i_ctrl.send_msg(m, nrep);
    chk("reply count", 16'(nrep), 16'(i_ctrl.reply_q.size()));
  endtask : xfer

  task automatic rd(input string what, input logic [7:0] c, input logic [15:0] exp, input int n);
    logic [15:0] got;
    xfer(c, 16'h0000, 0, n);
    got = (n == 2) ? {i_ctrl.reply_q[0], i_ctrl.reply_q[1]} : {8'h00, i_ctrl.reply_q[0]};
    chk(what, exp, got);
  endtask : rd

  function automatic logic [7:0] rt_exp(input logic [3:0] a, input logic [3:0] b);
    logic [7:0] e;
    for (int k = 0; k < 4; k++)
    begin
      e[2*k]   = a[k];
      e[2*k+1] = b[k];
    end
    return e;
  endfunction : rt_exp

  task automatic set_sig(input logic m, input logic [3:0] a, input logic [3:0] b,
                         input logic [3:0] c);
    @(posedge clock);
    #1;
    mux_mode = m;
    deb      = a;
    mux1     = b;
    in2      = c;
    repeat (40) @(posedge clock);
  endtask : set_sig

  task automatic t_reset;
    rd("interval", CMD_KEYINT_RD, {8'h00, KEYINT_RST}, 1);
    rd("mask", CMD_MASK_RD, {8'h00, MASK_RST}, 1);
    rd("scale byte", CMD_SCALE_RD, {8'h00, SCALE_RST}, 1);
    rd("gain word", CMD_TXGAIN_RD, TXGAIN_RST, 2);
    chk("gain out", TXGAIN_RST, gxw);
    chk("int_n", 16'h0001, {15'h0, int_n});
  endtask : t_reset

  task automatic t_scale;
    logic [7:0] v [2] = '{8'hf0, 8'h03};
    foreach (v[i])
    begin
      xfer(CMD_SCALE_WR, {v[i], 8'h00}, 1, 0);
      chk("atten/gain/loss", 16'(v[i][7:5]), {13'h0, atten, again, rloss});
      chk("code", 16'(v[i][4:0]), 16'(code));
      chk("step", 16'(6'({1'b0, v[i][4:0]} - 6'h10)), 16'(step));
      chk("loopback", 16'(v[i][4:0] == 5'h10), 16'(loopb));
      rd("scale rd", CMD_SCALE_RD, {8'h00, v[i]}, 1);
    end
  endtask : t_scale

  // third data byte is beyond the word and must be ignored
  task automatic t_gain;
    xfer(CMD_TXGAIN_WR, 16'h8c5a, 3, 0);
    chk("gain out", 16'h8c5a, gxw);
    chk("signs", 16'h000d, {12'h0, gxs});
    chk("shifts", 16'({3'd0, 3'd4, 3'd5, 3'd2}), {4'h0, gxm});
    rd("gain rd", CMD_TXGAIN_RD, 16'h8c5a, 2);
  endtask : t_gain

  task automatic t_interval;
    xfer(CMD_KEYINT_WR, 16'h0f00, 1, 0);
    rd("interval", CMD_KEYINT_RD, 16'h000f, 1);
    set_sig(1'b0, 4'h0, 4'h0, 4'h0);
    set_sig(1'b0, 4'h0, 4'h0, 4'h4);
    repeat (150) @(posedge clock);
    chk("filtered ci", 16'(rt_exp(4'h0, 4'h4)), 16'(ci));
    xfer(CMD_KEYINT_WR, 16'h0000, 1, 0);
  endtask : t_interval

  task automatic t_realtime;
    set_sig(1'b1, 4'h5, 4'h3, 4'hc);
    chk("ci muxed", 16'(rt_exp(4'h5, 4'h3)), 16'(ci));
    rd("rt muxed", CMD_RT_RD, 16'(rt_exp(4'h5, 4'h3)), 1);
    set_sig(1'b0, 4'ha, 4'h3, 4'hc);
    chk("ci second", 16'(rt_exp(4'ha, 4'hc)), 16'(ci));
    chk("int masked", 16'h0001, 16'(int_n));
    xfer(CMD_MASK_WR, 16'hfe00, 1, 0);
    rd("mask", CMD_MASK_RD, 16'h00fe, 1);
    set_sig(1'b0, 4'ha, 4'h3, 4'hd);
    chk("int still masked", 16'h0001, 16'(int_n));
    set_sig(1'b0, 4'hb, 4'h3, 4'hd);
    chk("int unmasked", 16'h0000, 16'(int_n));
    rd("rt keep", CMD_RT_RD, 16'(rt_exp(4'hb, 4'hd)), 1);
    chk("int kept", 16'h0000, 16'(int_n));
    rd("rt clear", CMD_RT_RD_CLR, 16'(rt_exp(4'hb, 4'hd)), 1);
    chk("int cleared", 16'h0001, 16'(int_n));
  endtask : t_realtime

  // a read code this block does not own gets no reply
  task automatic t_refuse;
    xfer(8'h53, 16'h0000, 0, 0);
  endtask : t_refuse

  initial
  begin
    mismatches = 0;
    checks     = 0;
    rstn       = 1'b0;
    mux_mode   = 1'b0;
    deb        = 4'h0;
    mux1       = 4'h0;
    in2        = 4'h0;
    // held over link edges too, the slower domain needs two of them
    repeat (4) @(posedge link_clk);
    @(posedge clock);
    #1;
    rstn = 1'b1;
    t_reset();
    t_scale();
    t_gain();
    t_interval();
    t_realtime();
    t_refuse();
    test_done();
  end

  initial
  begin
    #400us;
    mismatches++;
    test_done();
  end
endmodule : gcim_monitor_cmd_regs_test
`default_nettype wire
